// [shared/tcg_defs.vh]
// Register offsets, field layouts, reset values and source codes
`ifndef TCG_DEFS_VH
`define TCG_DEFS_VH

// ---------------------------------------------------------------
// Register map, one pair per timer instance
// ---------------------------------------------------------------
`define TCG_ADDR_W 3
`define TCG_OFS_CLK0 3'h0
`define TCG_OFS_GATE0 3'h1
`define TCG_OFS_CLK1 3'h2
`define TCG_OFS_GATE1 3'h3
`define TCG_OFS_CLK2 3'h4
`define TCG_OFS_GATE2 3'h5

// ---------------------------------------------------------------
// Field layout and reset values
// ---------------------------------------------------------------
`define TCG_CLK_FIELD_W 4
`define TCG_GATE_FIELD_W 5
`define TCG_CLK_RESET 4'h0
`define TCG_GATE_RESET 5'h00

// ---------------------------------------------------------------
// Source codes
// ---------------------------------------------------------------
`define TCG_CS_PIN 4'h0
`define TCG_CS_OVF_BASE 4'h8
`define TCG_CS_LC_BASE 4'hC
`define TCG_GS_PIN 5'h00
`define TCG_GS_FIRST_RSVD 5'h19
`define TCG_GS_OWN_BASE 5'h02

`endif

// [rtl/tcg_clock_mux.v]
// Clock source multiplexer for one timer instance
`include "tcg_defs.vh"

module tcg_clock_mux #(
  parameter INST = 0
) (
  input wire [3:0] code_in,
  input wire [15:0] sources_in,
  output reg clock_out,
  output reg reserved_out
);

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  localparam [3:0] OWN_CODE = `TCG_CS_OVF_BASE + INST + 1;

  always @* begin
    reserved_out = (code_in == OWN_CODE);
    // Own overflow would loop the counter on itself, so drive low
    if (reserved_out) begin
      clock_out = 1'b0;
    end else begin
      clock_out = sources_in[code_in];
    end
  end

endmodule

// [rtl/tcg_gate_mux.v]
// Gate source multiplexer for one timer instance
`include "tcg_defs.vh"

module tcg_gate_mux #(
  parameter INST = 0
) (
  input wire [4:0] code_in,
  input wire [24:0] sources_in,
  output reg gate_out,
  output reg reserved_out
);

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  localparam [4:0] OWN_CODE = `TCG_GS_OWN_BASE + 2 * INST;

  always @* begin
    reserved_out = (code_in == OWN_CODE) ||
                   (code_in >= `TCG_GS_FIRST_RSVD);
    if (reserved_out) begin
      gate_out = 1'b0;
    end else begin
      gate_out = sources_in[code_in];
    end
  end

endmodule

// [rtl/tcg_source_select.v]
// Clock and gate source selection for three 16-bit timers
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`include "tcg_defs.vh"

module tcg_source_select #(
  parameter NUM_TIMERS = 3
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire por_bor_in,
  input wire [`TCG_ADDR_W-1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire [2:0] clock_pin_input_in,
  input wire [2:0] gate_pin_input_in,
  input wire sys_clk_src_in,
  input wire sys_clk_div4_in,
  input wire digitally_controlled_osc_in,
  input wire low_freq_internal_osc_in,
  input wire medium_freq_internal_osc_in,
  input wire secondary_osc_in,
  input wire reference_clock_output_in,
  input wire eight_sixteen_bit_timer_ovf_in,
  input wire [2:0] timer_ovf_in,
  input wire [2:0] period_timer_output_in,
  input wire [1:0] measurement_timer_match_in,
  input wire [4:0] capture_compare_output_in,
  input wire [1:0] pwm_output_in,
  input wire numeric_oscillator_output_in,
  input wire [1:0] comparator_synced_in,
  input wire zero_cross_output_in,
  input wire [3:0] logic_cell_output_in,
  output wire [2:0] timer_clock_out,
  output wire [2:0] timer_gate_out,
  output wire [2:0] clock_reserved_out,
  output wire [2:0] gate_reserved_out
);

  // ---------------------------------------------------------------
  // Shared source vectors
  // ---------------------------------------------------------------
  wire [14:0] clk_common;
  wire [24:0] gate_common;

  assign clk_common = {logic_cell_output_in, timer_ovf_in,
                       eight_sixteen_bit_timer_ovf_in,
                       reference_clock_output_in, secondary_osc_in,
                       medium_freq_internal_osc_in,
                       low_freq_internal_osc_in,
                       digitally_controlled_osc_in, sys_clk_src_in,
                       sys_clk_div4_in};

  assign gate_common = {logic_cell_output_in, zero_cross_output_in,
                        comparator_synced_in, numeric_oscillator_output_in,
                        pwm_output_in, capture_compare_output_in,
                        measurement_timer_match_in,
                        period_timer_output_in[2], timer_ovf_in[2],
                        period_timer_output_in[1], timer_ovf_in[1],
                        period_timer_output_in[0], timer_ovf_in[0],
                        eight_sixteen_bit_timer_ovf_in,
                        1'b0};

  // ---------------------------------------------------------------
  // Select registers
  // ---------------------------------------------------------------
  // One register pair per timer, gathered here for the read path
  wire [`TCG_CLK_FIELD_W*NUM_TIMERS-1:0] clk_code_reg;
  wire [`TCG_GATE_FIELD_W*NUM_TIMERS-1:0] gate_code_reg;

  // Other resets leave the fields alone; only POR/BOR clears them
  wire clear_codes = !rst_n_in && por_bor_in;

  genvar i;
  generate
    for (i = 0; i < NUM_TIMERS; i = i + 1) begin : g_tmr
      localparam [2:0] CLK_OFS = 2 * i;
      localparam [2:0] GATE_OFS = 2 * i + 1;
      reg [3:0] clk_sel_reg;
      reg [4:0] gate_sel_reg;

      assign clk_code_reg[4*i +: 4] = clk_sel_reg;
      assign gate_code_reg[5*i +: 5] = gate_sel_reg;

      always @(posedge sys_clk_in) begin
        if (clear_codes) begin
          clk_sel_reg <= `TCG_CLK_RESET;
          gate_sel_reg <= `TCG_GATE_RESET;
        end else if (rst_n_in && wr_in) begin
          if (addr_in == CLK_OFS) begin
            clk_sel_reg <= wdata_in[3:0];
          end else if (addr_in == GATE_OFS) begin
            gate_sel_reg <= wdata_in[4:0];
          end
        end
      end

      tcg_clock_mux #(
        .INST(i)
      ) u_clk (
        .code_in(clk_code_reg[4*i +: 4]),
        .sources_in({clk_common, clock_pin_input_in[i]}),
        .clock_out(timer_clock_out[i]),
        .reserved_out(clock_reserved_out[i])
      );

      tcg_gate_mux #(
        .INST(i)
      ) u_gate (
        .code_in(gate_code_reg[5*i +: 5]),
        .sources_in({gate_common[24:1], gate_pin_input_in[i]}),
        .gate_out(timer_gate_out[i]),
        .reserved_out(gate_reserved_out[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  reg [7:0] rdata_next;

  always @* begin
    rdata_next = 8'h00;
    if (addr_in == `TCG_OFS_CLK0) begin
      rdata_next = {4'h0, clk_code_reg[3:0]};
    end else if (addr_in == `TCG_OFS_GATE0) begin
      rdata_next = {3'h0, gate_code_reg[4:0]};
    end else if (addr_in == `TCG_OFS_CLK1) begin
      rdata_next = {4'h0, clk_code_reg[7:4]};
    end else if (addr_in == `TCG_OFS_GATE1) begin
      rdata_next = {3'h0, gate_code_reg[9:5]};
    end else if (addr_in == `TCG_OFS_CLK2) begin
      rdata_next = {4'h0, clk_code_reg[11:8]};
    end else if (addr_in == `TCG_OFS_GATE2) begin
      rdata_next = {3'h0, gate_code_reg[14:10]};
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

// [verification/tcg_src_model.sv]
// Far-side model: oscillator, pin and peripheral output levels
module tcg_src_model (
  input wire logic clk_in,
  output logic [36:0] src_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial src_out = '0;
  // New pattern each cycle, so a stale or wrong select shows up
  always @(posedge clk_in) begin
    src_out <= 37'({$urandom, $urandom});
  end
endmodule

// [verification/tcg_chk.sv]
// Checker for register port and reserved flags of the selector
module tcg_chk (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire por_bor_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire [2:0] clock_reserved_out,
  input wire [2:0] gate_reserved_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_RD_IDLE:
    assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("rd idle");
  AST_CLK_HI:
    assert property (rd_in && !addr_in[0] |=> rdata_out[7:4] == 4'h0)
    else $error("clock upper bits");
  AST_GATE_HI:
    assert property (rd_in && addr_in[0] |=> rdata_out[7:5] == 3'h0)
    else $error("gate upper bits");
  AST_UNMAP:
    assert property (rd_in && addr_in[2:1] == 2'h3 |=> rdata_out == 8'h00)
    else $error("unmapped read");
  AST_GATE_BACK:
    assert property (wr_in && addr_in == 3'h1 ##2 rd_in && addr_in == 3'h1
      |=> rdata_out[4:0] == $past(wdata_in[4:0], 3)) else $error("gate back");
  AST_CLK_RSV:
    assert property (wr_in && addr_in == 3'h0
      |=> clock_reserved_out[0] == ($past(wdata_in[3:0]) == 4'h9))
    else $error("clock reserved");
  AST_GATE_RSV:
    assert property (wr_in && addr_in == 3'h3 |=> gate_reserved_out[1] ==
      ($past(wdata_in[4:0]) == 5'h04 || $past(wdata_in[4:0]) > 5'h18))
    else $error("gate reserved");
  AST_POR:
    assert property ($rose(rst_n_in) && $past(por_bor_in)
      |-> clock_reserved_out == 3'h0 && gate_reserved_out == 3'h0)
    else $error("por clear");
  AST_WARM:
    assert property ($rose(rst_n_in) && !$past(por_bor_in)
      |-> $stable(clock_reserved_out) && $stable(gate_reserved_out))
    else $error("warm keep");
endmodule
bind tcg_source_select tcg_chk u_tcg_chk (.sys_clk_in, .rst_n_in,
  .por_bor_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .clock_reserved_out, .gate_reserved_out);

// [verification/tcg_source_select_bench.sv]
// Self-checking bench for timer clock and gate source selection
module tcg_source_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, por = 1, wr = 0, rd = 0;
  logic [2:0] addr = 0, tco, tgo, cro, gro;
  logic [7:0] wd = 0, rdata;
  logic [36:0] s;
  int fail_count = 0, check_count = 0;
  always #2 clk = ~clk;
  tcg_src_model u_tcg_src_model (.clk_in(clk), .src_out(s));
  tcg_source_select u_tcg_source_select (.sys_clk_in(clk), .rst_n_in(rst_n),
    .por_bor_in(por), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .clock_pin_input_in(s[2:0]),
    .gate_pin_input_in(s[5:3]), .sys_clk_div4_in(s[6]), .sys_clk_src_in(s[7]),
    .digitally_controlled_osc_in(s[8]), .low_freq_internal_osc_in(s[9]),
    .medium_freq_internal_osc_in(s[10]), .secondary_osc_in(s[11]),
    .reference_clock_output_in(s[12]), .eight_sixteen_bit_timer_ovf_in(s[13]),
    .timer_ovf_in(s[16:14]), .period_timer_output_in(s[19:17]),
    .measurement_timer_match_in(s[21:20]),
    .capture_compare_output_in(s[26:22]), .pwm_output_in(s[28:27]),
    .numeric_oscillator_output_in(s[29]), .comparator_synced_in(s[31:30]),
    .zero_cross_output_in(s[32]), .logic_cell_output_in(s[36:33]),
    .timer_clock_out(tco), .timer_gate_out(tgo), .clock_reserved_out(cro),
    .gate_reserved_out(gro));
  function automatic logic exp_clk(int i, logic [4:0] c);
    logic [15:0] v;
    v = {s[36:33], s[16:6], s[i]};
    return (c[3:0] == 9 + i) ? 1'b0 : v[c[3:0]];
  endfunction
  function automatic logic exp_gate(int i, logic [4:0] c);
    logic [31:0] v;
    v = {7'h00, s[36:20], s[19], s[16], s[18], s[15], s[17], s[14:13], s[3+i]};
    return (c == 2 + 2 * i || c > 24) ? 1'b0 : v[c];
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded run: a hung handshake still reaches the verdict
  initial begin
    #20us;
    fail_count++;
    end_sim;
  end
  initial begin
    logic [7:0] d;
    void'($urandom(32'h967A));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    por <= 0;
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 32; c++) begin
        wreg(3'(2 * i), 8'(c));
        wreg(3'(2 * i + 1), {3'($urandom), c[4:0]});
        @(negedge clk);
        chk(tco[i], exp_clk(i, c[4:0]));
        chk(cro[i], c[3:0] == 9 + i);
        chk(tgo[i], exp_gate(i, c[4:0]));
        chk(gro[i], c == 2 + 2 * i || c > 24);
        rreg(3'(2 * i + 1), d);
        chk(d, {3'h0, c[4:0]});
        rreg(3'(2 * i), d);
        chk(d, {4'h0, c[3:0]});
        wreg(3'h6 | 3'($urandom_range(1)), 8'($urandom));
        rreg(3'h6 | 3'($urandom_range(1)), d);
        chk(d, 8'h00);
      end
    end
    wreg(3'h2, 8'h0B);
    @(posedge clk);
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    rreg(3'h2, d);
    chk(d, 8'h0B);
    @(posedge clk);
    rst_n <= 0;
    por <= 1;
    @(posedge clk);
    rst_n <= 1;
    por <= 0;
    rreg(3'h2, d);
    chk(d, 8'h00);
    end_sim;
  end
endmodule
